// ### pid_consts.svh
// constants for the pid setpoint/feedback controller
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH
`define PID_MODE_ENABLE_BIT 0
`define PID_MODE_INVERT_BIT 1
`define PID_MODE_DFB_BIT 2
`define PID_MODE_ADDCMD_BIT 3
`define PID_SP_KEYPAD 3'h0
`define PID_SP_AIN1 3'h1
`define PID_SP_AIN2 3'h2
`define PID_SP_STORED 3'h4
`define PID_SP_FREQCMD 3'h6
`define PID_SP_MULTISPD 3'h7
`define PID_FB_AIN1 3'h1
`define PID_FB_AIN2 3'h2
`define PID_FB_DIFF 3'h4
`define PID_FULL_SCALE 16'h2710
`define PID_CLK_HZ 25000000
`define PID_TICK_US 1000
`define PID_TICK_CYCLES ((`PID_CLK_HZ / 1000000) * `PID_TICK_US)
`define PID_RAMP_MAX_DSEC 8'hff
`define PID_LAG_MAX_CSEC 16'h03e8
`endif

// ### pid_controller.sv
// closed-loop pid controller with setpoint and feedback selection
//
// Behaviour
// - setpoint source picks keypad, inputs, stored, commands
// - analog setpoint maps full span to 0..100%
// - freq command setpoint as percent of rated
// - active multi-speed step as percent of rated
// - stored setpoint percentage used as target
// - feedback picks input one, two or difference
// - negative input difference feedback clamps to zero
// - same setpoint and feedback source raises conflict
// - mode bit0 enables controller
// - mode bit1 inverts output polarity
// - mode bit2 derivative on feedback else error
// - bit3 low: output alone sets frequency
// - bit3 high: add frequency command when running
// - reverse-allow permits negative output
// - setpoint ramps with 0.0..25.5 s time
// - programmable output lag 0.00..10.00
// - reverse not allowed: negative output held zero
// - lag filter sits after output limit
// - integral accumulator clamped to integral limit
// - bias added, scaled by output gain
`timescale 1ns/1ps
`include "pid_consts.svh"
module pid_controller #(
    parameter int AW = 12,
    parameter int TICK_CYCLES = `PID_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] setpointSel,
    input wire logic [2:0] feedbackSel,
    input wire logic [3:0] modeWord,
    input wire logic reverseAllow,
    input wire logic [15:0] keypadPct,
    input wire logic [15:0] storedPct,
    input wire logic [AW-1:0] analog_input_one,
    input wire logic [AW-1:0] analog_input_two,
    input wire logic [15:0] freqCmdHz,
    input wire logic [15:0] multiSpeedHz,
    input wire logic [15:0] ratedHz,
    input wire logic running,
    input wire logic [15:0] feedbackGain,
    input wire logic [15:0] propGain,
    input wire logic [15:0] integralTime,
    input wire logic [15:0] diffTime,
    input wire logic signed [15:0] biasPct,
    input wire logic [15:0] lagTime,
    input wire logic [15:0] integralLimit,
    input wire logic [15:0] outputLimit,
    input wire logic [15:0] outputGain,
    input wire logic [7:0] rampTime,
    output logic setting_conflict_alarm,
    output logic active,
    output logic signed [17:0] freqPct,
    output logic signed [17:0] pidOut
);
    // *********************************************
    // percentages are hundredths: 10000 = 100.00%
    // *********************************************
    localparam logic signed [17:0] FS = 18'(`PID_FULL_SCALE);
    if (AW < 4 || AW > 16) begin : g_bad_aw
        $error("analog width unsupported");
    end
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("tick count must be positive");
    end

    pid_pkg::pid_state_t state;
    logic [$clog2(TICK_CYCLES+1)-1:0] tickCnt;
    logic tick;
    logic [15:0] rawTarget;
    logic signed [17:0] target;
    logic [15:0] rawFb;
    logic signed [17:0] fbScaled;
    logic signed [17:0] err, prevD, dIn;
    logic signed [31:0] integ, pTerm, dTerm, sum;
    logic signed [17:0] limited, lagged;
    logic conflict;

    // *********************************************
    // control tick
    // *********************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tickCnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tickCnt == ($bits(tickCnt))'(TICK_CYCLES - 1));
            tickCnt <= (tickCnt == ($bits(tickCnt))'(TICK_CYCLES - 1)) ? '0 : tickCnt + 1'b1;
        end
    end

    // *********************************************
    // source selection
    // *********************************************
    function automatic logic [15:0] ain_pct(input logic [AW-1:0] v);
        ain_pct = 16'((32'(v) * 32'(`PID_FULL_SCALE)) / ((32'h1 << AW) - 1));
    endfunction
    function automatic logic [15:0] hz_pct(input logic [15:0] hz, input logic [15:0] r);
        logic [31:0] q;
        q = (r == 16'h0000) ? 32'h0 : (32'(hz) * 32'(`PID_FULL_SCALE)) / 32'(r);
        hz_pct = (q > 32'(`PID_FULL_SCALE)) ? 16'(`PID_FULL_SCALE) : q[15:0];
    endfunction

    always_comb begin
        case (setpointSel)
            `PID_SP_KEYPAD: rawTarget = keypadPct;
            `PID_SP_AIN1: rawTarget = ain_pct(analog_input_one);
            `PID_SP_AIN2: rawTarget = ain_pct(analog_input_two);
            `PID_SP_STORED: rawTarget = (storedPct > 16'(`PID_FULL_SCALE)) ?
                16'(`PID_FULL_SCALE) : storedPct;
            `PID_SP_FREQCMD: rawTarget = hz_pct(freqCmdHz, ratedHz);
            `PID_SP_MULTISPD: rawTarget = hz_pct(multiSpeedHz, ratedHz);
            default: rawTarget = 16'h0000;
        endcase
    end

    always_comb begin
        logic signed [17:0] d;
        d = 18'(ain_pct(analog_input_one)) - 18'(ain_pct(analog_input_two));
        case (feedbackSel)
            `PID_FB_AIN1: rawFb = ain_pct(analog_input_one);
            `PID_FB_AIN2: rawFb = ain_pct(analog_input_two);
            `PID_FB_DIFF: rawFb = (d < 0) ? 16'h0000 : d[15:0];
            default: rawFb = 16'h0000;
        endcase
    end

    // analog setpoint colliding with an analog feedback path
    always_comb begin
        conflict = 1'b0;
        if ((setpointSel == `PID_SP_AIN1) && (feedbackSel == `PID_FB_AIN1 ||
            feedbackSel == `PID_FB_DIFF)) conflict = 1'b1;
        if ((setpointSel == `PID_SP_AIN2) && (feedbackSel == `PID_FB_AIN2 ||
            feedbackSel == `PID_FB_DIFF)) conflict = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            setting_conflict_alarm <= 1'b0;
        end else begin
            setting_conflict_alarm <= conflict;
        end
    end

    // feedback gain in hundredths
    assign fbScaled = 18'((32'(rawFb) * 32'(feedbackGain)) / 32'd100);

    // *********************************************
    // setpoint ramp: full scale in rampTime tenths of seconds
    // *********************************************
    // eight fraction bits keep the step above zero up to the longest ramp time
    logic signed [25:0] targetFx;
    logic signed [25:0] stepFx;
    logic signed [25:0] rawTargetFx;
    assign rawTargetFx = $signed({2'b00, rawTarget, 8'h00});
    assign stepFx = (rampTime == 8'h00) ? 26'sh0000000 :
        26'((32'(`PID_FULL_SCALE) << 8) / (32'(rampTime) * 32'h64));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            targetFx <= '0;
        end else if (tick) begin
            if (rampTime == 8'h00) targetFx <= rawTargetFx;
            else if (rawTargetFx > targetFx + stepFx) targetFx <= targetFx + stepFx;
            else if (rawTargetFx < targetFx - stepFx) targetFx <= targetFx - stepFx;
            else targetFx <= rawTargetFx;
        end
    end
    assign target = 18'(targetFx >>> 8);

    // *********************************************
    // pid core sequencing
    // *********************************************
    function automatic logic signed [31:0] sat(input logic signed [31:0] v,
        input logic signed [31:0] lim);
        sat = (v > lim) ? lim : ((v < -lim) ? -lim : v);
    endfunction

    logic enabled;
    assign enabled = modeWord[`PID_MODE_ENABLE_BIT] && !conflict;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= pid_pkg::PID_IDLE;
        end else begin
            case (state)
                pid_pkg::PID_IDLE: state <= (tick && enabled) ? pid_pkg::PID_CALC : pid_pkg::PID_IDLE;
                pid_pkg::PID_CALC: state <= pid_pkg::PID_LIMIT;
                pid_pkg::PID_LIMIT: state <= pid_pkg::PID_OUT;
                pid_pkg::PID_OUT: state <= pid_pkg::PID_IDLE;
                default: state <= pid_pkg::PID_IDLE;
            endcase
        end
    end

    // error, with polarity applied here so the P, I and error-derivative terms follow it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err <= '0;
        end else if (tick) begin
            err <= modeWord[`PID_MODE_INVERT_BIT] ? fbScaled - target
                : target - fbScaled;
        end
    end

    // feedback derivative follows the polarity bit like the error does
    assign dIn = modeWord[`PID_MODE_DFB_BIT] ?
        (modeWord[`PID_MODE_INVERT_BIT] ? fbScaled : -fbScaled) : err;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            integ <= '0;
            prevD <= '0;
            pTerm <= '0;
            dTerm <= '0;
        end else if (!enabled) begin
            integ <= '0;
            prevD <= '0;
        end else if (state == pid_pkg::PID_CALC) begin
            pTerm <= sat((32'(err) * $signed(32'(propGain))) / 32'sh64, 32'sh9c40);
            // integral time in tenths of a second, 100 ticks per tenth
            if (integralTime != 16'h0000) begin
                integ <= sat(integ + (32'(err) * 32'sha) / $signed(32'(integralTime) * 32'h64),
                    $signed(32'(integralLimit) * 32'ha));
            end else begin
                integ <= '0;
            end
            dTerm <= sat((32'(dIn) - 32'(prevD)) * $signed(32'(diffTime)) * 32'sha,
                32'sh9c40);
            prevD <= dIn;
        end
    end

    // *********************************************
    // sum, bias, limits, reversal
    // *********************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sum <= '0;
        end else if (state == pid_pkg::PID_LIMIT) begin
            sum <= sat(pTerm + integ / 32'sha + dTerm
                + (32'(biasPct) * $signed(32'(outputGain)) / 32'sha),
                $signed(32'(outputLimit)));
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            limited <= '0;
        end else if (!enabled) begin
            limited <= '0;
        end else if (state == pid_pkg::PID_OUT) begin
            limited <= (!reverseAllow && sum < 0) ? 18'sh0 : 18'(sum);
        end
    end

    pid_lag_filter #(.W(18)) u_lag (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .lagCsec((lagTime > `PID_LAG_MAX_CSEC) ? `PID_LAG_MAX_CSEC : lagTime),
        .din(limited),
        .dout(lagged)
    );

    logic signed [17:0] cmdPct;
    assign cmdPct = 18'(hz_pct(freqCmdHz, ratedHz));

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pidOut <= '0;
            freqPct <= '0;
            active <= 1'b0;
        end else begin
            active <= enabled;
            pidOut <= lagged;
            if (!enabled) freqPct <= cmdPct;
            else if (modeWord[`PID_MODE_ADDCMD_BIT])
                freqPct <= running ? 18'(sat(32'(lagged) + 32'(cmdPct), 32'(FS))) : cmdPct;
            else freqPct <= lagged;
        end
    end

    // *********************************************
    // checks
    // *********************************************
    chk_conflict_alarm: assert property (@(posedge sys_clk) disable iff (rst)
        (setpointSel == `PID_SP_AIN1 && feedbackSel == `PID_FB_AIN1) |=> setting_conflict_alarm)
        else $error("conflict not flagged");
    chk_no_reverse: assert property (@(posedge sys_clk) disable iff (rst)
        !reverseAllow && state == pid_pkg::PID_OUT |=> limited >= 0)
        else $error("negative output with reversal off");
    chk_disabled_out: assert property (@(posedge sys_clk) disable iff (rst)
        !enabled |=> active == 1'b0 && limited == 0)
        else $error("disabled controller drives output");
    chk_integ_limit: assert property (@(posedge sys_clk) disable iff (rst)
        state == pid_pkg::PID_LIMIT && $stable(integralLimit)
        |-> integ <= $signed(32'(integralLimit) * 32'ha)
        && integ >= -$signed(32'(integralLimit) * 32'ha))
        else $error("integral beyond limit");
    sequence seq_calc;
        state == pid_pkg::PID_CALC ##1 state == pid_pkg::PID_LIMIT;
    endsequence
    chk_seq_order: assert property (@(posedge sys_clk) disable iff (rst)
        seq_calc |=> state == pid_pkg::PID_OUT ##1 state == pid_pkg::PID_IDLE)
        else $error("pid sequence broken");
    chk_output_limit: assert property (@(posedge sys_clk) disable iff (rst)
        state == pid_pkg::PID_OUT && $stable(outputLimit) |-> sum <= $signed(32'(outputLimit)))
        else $error("sum beyond output limit");
    chk_pid_only: assert property (@(posedge sys_clk) disable iff (rst)
        enabled && !modeWord[`PID_MODE_ADDCMD_BIT] |=> freqPct == $past(lagged))
        else $error("pid-only output mismatch");
    chk_diff_clamp: assert property (@(posedge sys_clk) disable iff (rst)
        feedbackSel == `PID_FB_DIFF && analog_input_one < analog_input_two |-> rawFb == 16'h0000)
        else $error("negative difference not clamped");
endmodule : pid_controller

// ### pid_lag_filter.sv
// first-order low-pass used as the output lag
`timescale 1ns/1ps
module pid_lag_filter #(
    parameter int W = 18
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [15:0] lagCsec,
    input wire logic signed [W-1:0] din,
    output logic signed [W-1:0] dout
);
    logic signed [W+15:0] acc;
    logic signed [W+15:0] diff;
    logic [15:0] div;
    if (W < 2) begin : g_bad_w
        $error("filter width too small");
    end
    // one tick = 1 ms, so time constant in ticks is lag * 10
    assign div = (lagCsec == 16'h0000) ? 16'h0001 : 16'(lagCsec * 16'h000a);
    assign diff = ((W+16)'(din) <<< 16) - acc;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc <= '0;
        end else if (tick) begin
            if (lagCsec == 16'h0000) begin
                acc <= (W+16)'(din) <<< 16;
            end else begin
                acc <= acc + diff / $signed({1'b0, div});
            end
        end
    end
    assign dout = W'(acc >>> 16);
endmodule : pid_lag_filter

// ### pid_pkg.sv
// types for the pid setpoint/feedback controller
package pid_pkg;
    typedef enum logic [1:0] {
        PID_IDLE = 2'b00,
        PID_CALC = 2'b01,
        PID_LIMIT = 2'b10,
        PID_OUT = 2'b11
    } pid_state_t;
endpackage : pid_pkg

// ### tb_pid_setpoint_feedback_control.sv
// self-checking testbench for the pid setpoint/feedback controller
`timescale 1ns/1ps
module tb_pid_setpoint_feedback_control;
    // ************************************************
    // stimulus and observed signals
    // ************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] setpointSel, feedbackSel;
    logic [3:0] modeWord;
    logic reverseAllow, running;
    logic [15:0] keypadPct, storedPct, freqCmdHz, multiSpeedHz, ratedHz, feedbackGain;
    logic [15:0] propGain, integralTime, diffTime, lagTime, integralLimit, outputLimit;
    logic [15:0] outputGain;
    logic signed [15:0] biasPct;
    logic [7:0] rampTime;
    logic [11:0] analogOne, analogTwo;
    logic alarm, active;
    logic signed [17:0] freqPct, pidOut;
    int nMismatch = 0;
    int nTests = 0;

    always #20 sys_clk = ~sys_clk;

    // short tick so a settle span covers a couple of dozen control updates
    pid_controller #(.AW(12), .TICK_CYCLES(25)) dut (
        .sys_clk(sys_clk), .rst(rst), .setpointSel(setpointSel), .feedbackSel(feedbackSel),
        .modeWord(modeWord), .reverseAllow(reverseAllow), .keypadPct(keypadPct),
        .storedPct(storedPct), .analog_input_one(analogOne), .analog_input_two(analogTwo),
        .freqCmdHz(freqCmdHz), .multiSpeedHz(multiSpeedHz), .ratedHz(ratedHz),
        .running(running), .feedbackGain(feedbackGain), .propGain(propGain),
        .integralTime(integralTime), .diffTime(diffTime), .biasPct(biasPct),
        .lagTime(lagTime), .integralLimit(integralLimit), .outputLimit(outputLimit),
        .outputGain(outputGain), .rampTime(rampTime), .setting_conflict_alarm(alarm),
        .active(active), .freqPct(freqPct), .pidOut(pidOut));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic closeOut();
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : closeOut

    task automatic chkEq(input logic signed [17:0] got, input logic signed [17:0] exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %0t value %0d expected %0d", $time, got, exp);
        end
    endtask : chkEq

    task automatic chkBit(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkBit

    task automatic setBase();
        setpointSel = 3'h0;
        feedbackSel = 3'h1;
        modeWord = 4'h1;
        reverseAllow = 1'b0;
        running = 1'b0;
        keypadPct = 16'h0000;
        storedPct = 16'h0000;
        analogOne = 12'h000;
        analogTwo = 12'h000;
        freqCmdHz = 16'h0000;
        multiSpeedHz = 16'h0000;
        ratedHz = 16'h003c;
        propGain = 16'h0064;
        // long integral time keeps the integrator out of the way of exact checks
        integralTime = 16'h03e8;
        lagTime = 16'h0000;
        outputLimit = 16'h2710;
        rampTime = 8'h00;
        feedbackGain = 16'h0064;
        diffTime = 16'h0000;
        biasPct = 16'sh0000;
        integralLimit = 16'h2710;
        outputGain = 16'h000a;
    endtask : setBase

    task automatic restart();
        @(negedge sys_clk);
        rst = 1'b1;
        setBase();
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
    endtask : restart

    task automatic settle();
        repeat (600) @(negedge sys_clk);
    endtask : settle

    task automatic setFb(input logic [11:0] v);
        if (feedbackSel == 3'h2) analogTwo = v;
        else analogOne = v;
    endtask : setFb

    // ************************************************
    // scenarios
    // ************************************************
    task automatic testSource(input logic [2:0] sel);
        restart();
        setpointSel = sel;
        feedbackSel = (sel == 3'h1) ? 3'h2 : 3'h1;
        case (sel)
            3'h0: keypadPct = 16'h2710;
            3'h1: analogOne = 12'hfff;
            3'h2: analogTwo = 12'hfff;
            3'h4: storedPct = 16'h2710;
            3'h6: freqCmdHz = 16'h003c;
            default: multiSpeedHz = 16'h003c;
        endcase
        setFb(12'hfff);
        settle();
        chkEq(pidOut, 18'sh00000);
        setFb(12'h000);
        settle();
        chkBit(pidOut > 0, 1'b1);
    endtask : testSource

    task automatic testReserved(input logic [2:0] sel);
        restart();
        setpointSel = sel;
        keypadPct = 16'h2710;
        storedPct = 16'h2710;
        analogTwo = 12'hfff;
        freqCmdHz = 16'h003c;
        multiSpeedHz = 16'h003c;
        settle();
        chkEq(pidOut, 18'sh00000);
    endtask : testReserved

    task automatic testFeedback();
        restart();
        feedbackSel = 3'h4;
        // reversal on, so an unclamped negative difference would show as a negative output
        reverseAllow = 1'b1;
        analogTwo = 12'hfff;
        settle();
        chkEq(pidOut, 18'sh00000);
        keypadPct = 16'h2710;
        analogOne = 12'hfff;
        analogTwo = 12'h000;
        settle();
        chkEq(pidOut, 18'sh00000);
        feedbackSel = 3'h2;
        analogOne = 12'h000;
        analogTwo = 12'hfff;
        settle();
        chkEq(pidOut, 18'sh00000);
    endtask : testFeedback

    task automatic testConflict(input logic [2:0] sp, input logic [2:0] fb, input logic exp);
        restart();
        setpointSel = sp;
        feedbackSel = fb;
        repeat (3) @(negedge sys_clk);
        chkBit(alarm, exp);
        chkBit(active, ~exp);
    endtask : testConflict

    task automatic testPolarity();
        restart();
        keypadPct = 16'h2710;
        modeWord = 4'h3;
        reverseAllow = 1'b1;
        settle();
        chkBit(pidOut < 0, 1'b1);
        reverseAllow = 1'b0;
        settle();
        chkEq(pidOut, 18'sh00000);
        restart();
        analogOne = 12'hfff;
        settle();
        chkEq(pidOut, 18'sh00000);
    endtask : testPolarity

    task automatic testOutputPath();
        restart();
        modeWord = 4'h0;
        freqCmdHz = 16'h001e;
        settle();
        chkBit(active, 1'b0);
        chkEq(freqPct, 18'sh01388);
        modeWord = 4'h9;
        keypadPct = 16'h2710;
        outputLimit = 16'h07d0;
        settle();
        chkBit(active, 1'b1);
        chkEq(freqPct, 18'sh01388);
        running = 1'b1;
        repeat (3) @(negedge sys_clk);
        chkEq(freqPct, 18'sh01b58);
        modeWord = 4'h1;
        settle();
        chkEq(freqPct, 18'sh007d0);
    endtask : testOutputPath

    task automatic testShaping();
        restart();
        keypadPct = 16'h2710;
        propGain = 16'h03e8;
        outputLimit = 16'h07d0;
        settle();
        chkEq(pidOut, 18'sh007d0);
        restart();
        keypadPct = 16'h2710;
        rampTime = 8'h0a;
        repeat (250) @(negedge sys_clk);
        chkBit(pidOut < 1000, 1'b1);
        restart();
        keypadPct = 16'h2710;
        lagTime = 16'h0064;
        repeat (250) @(negedge sys_clk);
        chkBit(pidOut < 2000, 1'b1);
    endtask : testShaping

    task automatic testTerms();
        restart();
        keypadPct = 16'h2710;
        propGain = 16'h0000;
        integralTime = 16'h0001;
        integralLimit = 16'h01f4;
        settle();
        chkEq(pidOut, 18'sh001f4);
        restart();
        biasPct = 16'sh03e8;
        outputGain = 16'h0014;
        settle();
        chkEq(pidOut, 18'sh007d0);
    endtask : testTerms

    // a setpoint step kicks the error derivative but not the feedback derivative
    task automatic testDerivative(input logic [3:0] mode, input logic expKick);
        logic seen;
        restart();
        modeWord = mode;
        propGain = 16'h0000;
        integralTime = 16'h0000;
        diffTime = 16'h0064;
        repeat (100) @(negedge sys_clk);
        keypadPct = 16'h2710;
        seen = 1'b0;
        repeat (150) begin
            @(negedge sys_clk);
            if (pidOut != 18'sh00000) seen = 1'b1;
        end
        chkBit(seen, expKick);
    endtask : testDerivative

    // ************************************************
    // main sequence and watchdog
    // ************************************************
    initial begin
        setBase();
        repeat (6) @(negedge sys_clk);
        chkBit(alarm, 1'b0);
        chkEq(pidOut, 18'sh00000);
        rst = 1'b0;
        testSource(3'h0);
        testSource(3'h1);
        testSource(3'h2);
        testSource(3'h4);
        testSource(3'h6);
        testSource(3'h7);
        testReserved(3'h3);
        testReserved(3'h5);
        testFeedback();
        testConflict(3'h1, 3'h1, 1'b1);
        testConflict(3'h2, 3'h2, 1'b1);
        testConflict(3'h1, 3'h4, 1'b1);
        testConflict(3'h2, 3'h4, 1'b1);
        testConflict(3'h1, 3'h2, 1'b0);
        testPolarity();
        testOutputPath();
        testShaping();
        testTerms();
        testDerivative(4'h1, 1'b1);
        testDerivative(4'h5, 1'b0);
        closeOut();
    end

    // the full sequence needs under 0.7 ms of simulated time
    initial begin
        #2000000;
        nMismatch++;
        closeOut();
    end
endmodule : tb_pid_setpoint_feedback_control
